// >>> verilog/spc_ctrl0.sv
`timescale 1ns/1ns
`include "spc_regs.svh"
module spc_ctrl0
	import spc_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// serial pins
	input  wire logic       serial_data,
	input  wire logic       serial_strobe,
	input  wire logic       serial_frame_n,
	// detector status from signal path
	input  wire logic       canceller_converged,
	input  wire logic       far_speech,
	input  wire logic       near_speech,
	// control outputs
	output logic            mic_preamp_en,
	output logic            half_duplex_off,
	output logic            half_duplex_force,
	output logic [1:0]      echo_decay_grade,
	output logic            acoustic_grade_en,
	output logic            line_grade_en,
	output logic [3:0]      receive_volume_code,
	output logic            receive_agc_en,
	output logic            receive_mute,
	output logic            transmit_suppress_off,
	output logic            transmit_suppress_mode,
	output logic            transmit_suppress_active,
	output spc_pkg::spc_coef_t acoustic_coef_control
);
	import spc_pkg::*;

	////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic data_s;
	logic strobe_s;
	logic frame_n_s;
	logic strobe_prev_q;
	logic frame_prev_q;
	logic strobe_rise;
	logic poll_tick;

	spc_sync u_sync_data (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (serial_data),
		.pin_sync (data_s)
	);
	spc_sync u_sync_strobe (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (serial_strobe),
		.pin_sync (strobe_s)
	);
	spc_sync u_sync_frame (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (serial_frame_n),
		.pin_sync (frame_n_s)
	);
	spc_poll u_poll (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (poll_tick)
	);

	// rising strobe found on synchronised copy
	assign strobe_rise = strobe_s & ~strobe_prev_q;

	////////////////////////////////////////////////////////////////
	// serial receiver state
	spc_state_t                state_q;
	spc_state_t                state_d;
	logic [`SPC_WORD_W-1:0]    shift_q;
	logic [`SPC_WORD_W-1:0]    shift_d;
	logic [4:0]                bits_q;
	logic [4:0]                bits_d;
	logic [2:0]                tail_q;
	logic [2:0]                tail_d;
	logic                      pend_q;
	logic                      pend_d;
	logic [`SPC_WORD_W-1:0]    hold_q;
	logic [`SPC_WORD_W-1:0]    hold_d;

	// receiver next state
	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bits_d  = bits_q;
		tail_d  = tail_q;
		pend_d  = pend_q;
		hold_d  = hold_q;
		// pending word consumed at the poll instant
		if (poll_tick) begin
			pend_d = 1'b0;
		end
		case (state_q)
			SPC_IDLE: begin
				// frame opens on falling frame, strobe low
				// previous level resets low, so the synchroniser's own
				// reset low is never taken for an opening edge
				if (!frame_n_s && frame_prev_q && !strobe_s) begin
					state_d = SPC_SHIFT;
					bits_d  = '0;
				end
			end
			SPC_SHIFT: begin
				if (frame_n_s) begin
					if (bits_q >= `SPC_BIT_COUNT) begin
						state_d = SPC_TAIL;
						tail_d  = '0;
					end else begin
						state_d = SPC_IDLE;
					end
				end else if (strobe_rise) begin
					shift_d = {shift_q[`SPC_WORD_W-2:0], data_s};
					if (bits_q < `SPC_BIT_COUNT) begin
						bits_d = bits_q + `SPC_CNT_ONE;
					end
				end
			end
			SPC_TAIL: begin
				if (!frame_n_s) begin
					state_d = SPC_SHIFT;
					bits_d  = '0;
				end else if (strobe_rise) begin
					if (tail_q + `SPC_TAIL_ONE >= `SPC_TAIL_PULSES) begin
						state_d = SPC_IDLE;
						hold_d  = shift_q;
						pend_d  = 1'b1;
					end else begin
						tail_d = tail_q + `SPC_TAIL_ONE;
					end
				end
			end
			default: begin
				state_d = SPC_IDLE;
			end
		endcase
	end

	// receiver registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q       <= SPC_IDLE;
			shift_q       <= '0;
			bits_q        <= '0;
			tail_q        <= '0;
			pend_q        <= 1'b0;
			hold_q        <= '0;
			strobe_prev_q <= 1'b0;
			frame_prev_q  <= 1'b0;
		end else begin
			state_q       <= state_d;
			shift_q       <= shift_d;
			bits_q        <= bits_d;
			tail_q        <= tail_d;
			pend_q        <= pend_d;
			hold_q        <= hold_d;
			strobe_prev_q <= strobe_s;
			frame_prev_q  <= frame_n_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// control word zero
	logic [`SPC_WORD_W-1:0] reg0_q;
	logic [`SPC_WORD_W-1:0] reg0_d;

	// update on poll when addressed
	always_comb begin
		reg0_d = reg0_q;
		if (poll_tick && pend_q &&
		    hold_q[`SPC_ADDR_MSB:`SPC_ADDR_LSB] == `SPC_ADDR_REG0) begin
			reg0_d = hold_q;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg0_q <= `SPC_REG0_RESET;
		end else begin
			reg0_q <= reg0_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// decoded controls
	logic [3:0]  vol;
	logic [1:0]  acc;
	logic [1:0]  grade;
	spc_coef_t   coef_d;
	logic        mic_d;
	logic        hd_off_d;
	logic        hd_force_d;
	logic        grade_en_d;
	logic        mute_d;
	logic        agc_d;
	logic        ts_off_d;
	logic        ts_mode_d;
	logic        ts_act_d;

	// word fields
	assign vol   = reg0_q[`SPC_VOL_MSB:`SPC_VOL_LSB];
	assign acc   = reg0_q[`SPC_ACC_MSB:`SPC_ACC_LSB];
	assign grade = reg0_q[`SPC_GB_MSB:`SPC_GB_LSB];

	// next output values from the one applied word, force and suppress also from detector inputs
	always_comb begin
		mic_d      = reg0_q[`SPC_MIC_BIT];
		hd_off_d   = reg0_q[`SPC_HDD_BIT];
		grade_en_d = (grade != `SPC_GB_NONE);
		mute_d     = (vol == `SPC_VOL_MUTE);
		agc_d      = (vol < `SPC_VOL_ZERO_DB);
		ts_off_d   = reg0_q[`SPC_TSD_BIT];
		ts_mode_d  = reg0_q[`SPC_TSM_BIT];
		case (acc)
			`SPC_ACC_CLEAR:  coef_d = SPC_COEF_CLEAR;
			`SPC_ACC_FREEZE: coef_d = SPC_COEF_FREEZE;
			default:         coef_d = SPC_COEF_ADAPT;
		endcase
		hd_force_d = !reg0_q[`SPC_HDD_BIT] &&
		             (!canceller_converged || coef_d == SPC_COEF_CLEAR);
		ts_act_d   = !reg0_q[`SPC_TSD_BIT] && !near_speech &&
		             (!reg0_q[`SPC_TSM_BIT] || far_speech);
	end

	// registered outputs, reset shows the word's reset image, with transmit_suppress_active held low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mic_preamp_en            <= 1'b1;
			half_duplex_off          <= 1'b0;
			half_duplex_force        <= 1'b1;
			echo_decay_grade         <= `SPC_GB_RESET;
			acoustic_grade_en        <= 1'b1;
			line_grade_en            <= 1'b0;
			receive_volume_code      <= `SPC_VOL_RESET;
			receive_agc_en           <= 1'b1;
			receive_mute             <= 1'b0;
			transmit_suppress_off    <= 1'b0;
			transmit_suppress_mode   <= 1'b0;
			transmit_suppress_active <= 1'b0;
			acoustic_coef_control    <= SPC_COEF_ADAPT;
		end else begin
			mic_preamp_en            <= mic_d;
			half_duplex_off          <= hd_off_d;
			half_duplex_force        <= hd_force_d;
			echo_decay_grade         <= grade;
			acoustic_grade_en        <= grade_en_d;
			line_grade_en            <= 1'b0;
			receive_volume_code      <= vol;
			receive_mute             <= mute_d;
			receive_agc_en           <= agc_d;
			transmit_suppress_off    <= ts_off_d;
			transmit_suppress_mode   <= ts_mode_d;
			transmit_suppress_active <= ts_act_d;
			acoustic_coef_control    <= coef_d;
		end
	end
endmodule : spc_ctrl0

// >>> verilog/spc_regs.svh
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// word layout
`define SPC_WORD_W        16
`define SPC_ADDR_MSB      3
`define SPC_ADDR_LSB      0
`define SPC_ADDR_REG0     4'h0
`define SPC_MIC_BIT       15
`define SPC_HDD_BIT       14
`define SPC_GB_MSB        13
`define SPC_GB_LSB        12
`define SPC_VOL_MSB       11
`define SPC_VOL_LSB       8
`define SPC_TSD_BIT       7
`define SPC_ACC_MSB       6
`define SPC_ACC_LSB       5
`define SPC_TSM_BIT       4

// reset image of control word zero
`define SPC_REG0_RESET    16'ha400
`define SPC_GB_RESET      2'h2
`define SPC_VOL_RESET     4'h4

// decay grade and coefficient codes
`define SPC_GB_NONE       2'h0
`define SPC_ACC_CLEAR     2'h1
`define SPC_ACC_FREEZE    2'h2

// receive volume codes
`define SPC_VOL_ZERO_DB   4'ha
`define SPC_VOL_MUTE      4'hf

// frame handling
`define SPC_BIT_COUNT     5'h10
`define SPC_TAIL_PULSES   3'h4
`define SPC_CNT_ONE       5'h01
`define SPC_TAIL_ONE      3'h1

// poll interval in ns and cycles at 50 MHz
`define SPC_POLL_NS       125000
`define SPC_CLK_NS        20
`define SPC_POLL_CYC      (`SPC_POLL_NS / `SPC_CLK_NS)
`define SPC_POLL_W        13

`endif

// >>> verilog/spc_pkg.sv
package spc_pkg;
	// echo canceller coefficient modes
	typedef enum logic [1:0] {
		SPC_COEF_ADAPT,
		SPC_COEF_CLEAR,
		SPC_COEF_FREEZE
	} spc_coef_t;

	// serial receiver states
	typedef enum logic [1:0] {
		SPC_IDLE,
		SPC_SHIFT,
		SPC_TAIL
	} spc_state_t;
endpackage : spc_pkg

// >>> verilog/spc_sync.sv
`timescale 1ns/1ns
// two flop synchroniser for one pin
module spc_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// pin and result
	input  wire logic pin_in,
	output logic      pin_sync
);
	logic meta_q;

	// first flop read only by the second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q   <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule : spc_sync

// >>> verilog/spc_poll.sv
`timescale 1ns/1ns
`include "spc_regs.svh"
// poll tick divider, one pulse per interval
module spc_poll (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// tick out
	output logic      tick
);
	logic [`SPC_POLL_W-1:0] cnt_q;
	logic [`SPC_POLL_W-1:0] cnt_d;
	logic                   tick_d;

	// next count
	always_comb begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 1'b1;
		if (cnt_q == `SPC_POLL_W'(`SPC_POLL_CYC - 1)) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	// register count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= tick_d;
		end
	end
endmodule : spc_poll

// >>> verif/spc_ctrl0_chk.sv
`timescale 1ns/1ns
// watches control word zero outputs against each other and against detector inputs
module spc_ctrl0_chk
	import spc_pkg::*;
(
	// clock, reset and link pins
	input wire logic sys_clk, rst, serial_data, serial_strobe, serial_frame_n,
	// detector inputs
	input wire logic canceller_converged, far_speech, near_speech,
	// control outputs
	input wire logic mic_preamp_en, half_duplex_off, half_duplex_force,
	input wire logic [1:0] echo_decay_grade,
	input wire logic acoustic_grade_en, line_grade_en, receive_agc_en, receive_mute,
	input wire logic [3:0] receive_volume_code,
	input wire logic transmit_suppress_off, transmit_suppress_mode, transmit_suppress_active,
	input spc_pkg::spc_coef_t acoustic_coef_control
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// volume, grading and coefficient mode flags
	a_mute_code: assert property (
		receive_mute == (receive_volume_code == 4'hf))
		else $error("mute flag off volume code");
	a_agc_split: assert property (
		receive_agc_en == (receive_volume_code < 4'ha))
		else $error("gain control flag off volume code");
	a_line_grade: assert property (!line_grade_en)
		else $error("line canceller graded");
	a_acoustic_grade: assert property (
		acoustic_grade_en == (echo_decay_grade != 2'h0))
		else $error("acoustic grading flag wrong");
	a_coef_legal: assert property (acoustic_coef_control != 2'h3)
		else $error("reserved coefficient mode out");
	////////////////////////////////////////////////////////////////
	// transmit suppression
	a_near_release: assert property (
		$past(near_speech) |-> !transmit_suppress_active)
		else $error("suppression kept during near speech");
	a_suppress_off: assert property (
		transmit_suppress_off && $stable(transmit_suppress_off)
		|-> !transmit_suppress_active)
		else $error("suppression while disabled");
	a_far_only: assert property (
		transmit_suppress_mode && $stable(transmit_suppress_mode)
		&& $past(!far_speech) |-> !transmit_suppress_active)
		else $error("suppression without far speech");
	a_noise_guard: assert property (
		!$past(rst) && !transmit_suppress_off
		&& !transmit_suppress_mode && $stable({transmit_suppress_off, transmit_suppress_mode})
		&& $past(!near_speech) |-> transmit_suppress_active)
		else $error("noise guard not engaged");
	////////////////////////////////////////////////////////////////
	// half duplex forcing
	a_untrained_half: assert property (
		$past(!canceller_converged) && !half_duplex_off
		&& $stable(half_duplex_off) |-> half_duplex_force)
		else $error("no half duplex while untrained");
	a_half_blocked: assert property (
		half_duplex_off && $stable(half_duplex_off)
		|-> !half_duplex_force)
		else $error("half duplex while disabled");
	a_clear_half: assert property (
		acoustic_coef_control == SPC_COEF_CLEAR
		&& $stable(acoustic_coef_control) && !half_duplex_off && $stable(half_duplex_off)
		|-> half_duplex_force)
		else $error("clear mode without half duplex");
endmodule : spc_ctrl0_chk

bind spc_ctrl0 spc_ctrl0_chk chk (
	.sys_clk(sys_clk), .rst(rst), .serial_data(serial_data),
	.serial_strobe(serial_strobe), .serial_frame_n(serial_frame_n),
	.canceller_converged(canceller_converged), .far_speech(far_speech),
	.near_speech(near_speech), .mic_preamp_en(mic_preamp_en),
	.half_duplex_off(half_duplex_off), .half_duplex_force(half_duplex_force),
	.echo_decay_grade(echo_decay_grade), .acoustic_grade_en(acoustic_grade_en),
	.line_grade_en(line_grade_en), .receive_agc_en(receive_agc_en),
	.receive_mute(receive_mute), .receive_volume_code(receive_volume_code),
	.transmit_suppress_off(transmit_suppress_off),
	.transmit_suppress_mode(transmit_suppress_mode),
	.transmit_suppress_active(transmit_suppress_active),
	.acoustic_coef_control(acoustic_coef_control)
);

// >>> verif/spc_host.sv
`timescale 1ns/1ns
// host side of the three wire control link
module spc_host (
	// link pins
	output logic serial_data,
	output logic serial_strobe,
	output logic serial_frame_n
);
	// idle link: strobe still, frame high
	initial begin
		serial_data    = 1'b0;
		serial_strobe  = 1'b0;
		serial_frame_n = 1'b1;
	end
	// one strobe pulse, 80 ns low then 80 ns high
	task automatic pulse();
		#80 serial_strobe = 1'b1;
		#80 serial_strobe = 1'b0;
	endtask : pulse
	task automatic send(input logic [15:0] w, input int n);
		serial_frame_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			serial_data = w[i];
			pulse();
		end
		serial_data = ~serial_data; // released line shows no stale level
		#80 serial_frame_n = 1'b1;
		repeat (4) pulse();
		#125200;
	endtask : send
endmodule : spc_host

// >>> verif/spc_ctrl0_tb.sv
`timescale 1ns/1ns
module spc_ctrl0_tb;
	// stimulus and observed signals
	logic sys_clk, rst, canceller_converged, far_speech, near_speech;
	logic serial_data, serial_strobe, serial_frame_n;
	logic mic_preamp_en, half_duplex_off, half_duplex_force, acoustic_grade_en;
	logic line_grade_en, receive_agc_en, receive_mute, transmit_suppress_off;
	logic transmit_suppress_mode, transmit_suppress_active;
	logic [1:0] echo_decay_grade;
	logic [3:0] receive_volume_code;
	spc_pkg::spc_coef_t acoustic_coef_control;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	wire logic [14:0] obs = {mic_preamp_en, half_duplex_off, echo_decay_grade,
		acoustic_grade_en, receive_volume_code, receive_agc_en, receive_mute,
		transmit_suppress_off, transmit_suppress_mode, acoustic_coef_control};
	// words sent and the field image each should give
	localparam logic [15:0] ROW_WORD [5] = '{16'h0000, 16'h5a90, 16'hbfa0, 16'he9c0, 16'h0e70};
	localparam logic [14:0] ROW_EXP [5] = '{15'h0020, 15'h2e8c, 15'h5fd9, 15'h766a, 15'h0384};
	////////////////////////////////////////////////////////////////
	spc_host host (.serial_data(serial_data), .serial_strobe(serial_strobe),
		.serial_frame_n(serial_frame_n));
	spc_ctrl0 dut (.sys_clk(sys_clk), .rst(rst), .serial_data(serial_data),
		.serial_strobe(serial_strobe), .serial_frame_n(serial_frame_n),
		.canceller_converged(canceller_converged), .far_speech(far_speech),
		.near_speech(near_speech), .mic_preamp_en(mic_preamp_en),
		.half_duplex_off(half_duplex_off), .half_duplex_force(half_duplex_force),
		.echo_decay_grade(echo_decay_grade), .acoustic_grade_en(acoustic_grade_en),
		.line_grade_en(line_grade_en), .receive_volume_code(receive_volume_code),
		.receive_agc_en(receive_agc_en), .receive_mute(receive_mute),
		.transmit_suppress_off(transmit_suppress_off),
		.transmit_suppress_mode(transmit_suppress_mode),
		.transmit_suppress_active(transmit_suppress_active),
		.acoustic_coef_control(acoustic_coef_control));
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// verdict and end of run
	task automatic give_verdict();
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// detector inputs just after an edge, then let them settle
	task automatic drive(input logic conv, input logic far, input logic near);
		@(posedge sys_clk);
		#2;
		canceller_converged = conv;
		far_speech = far;
		near_speech = near;
		repeat (3) @(posedge sys_clk);
		#2;
	endtask : drive
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			give_verdict();
		end
	end
	// main sequence
	initial begin
		rst = 1'b1;
		canceller_converged = 1'b0;
		far_speech = 1'b0;
		near_speech = 1'b0;
		repeat (3) @(posedge sys_clk);
		#2 rst = 1'b0;
		@(posedge sys_clk);
		#2;
		check("reset image", obs, 15'h5520);
		check("untrained force", 15'(half_duplex_force), 15'h0001);
		drive(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			host.send(ROW_WORD[i], 16);
			check("word fields", obs, ROW_EXP[i]);
			check("clear force", 15'(half_duplex_force),
				15'(!ROW_WORD[i][14] && ROW_WORD[i][6:5] == 2'b01));
			check("suppress state", 15'(transmit_suppress_active),
				15'(!ROW_WORD[i][7] && !ROW_WORD[i][4]));
			check("line grade", 15'(line_grade_en), 15'h0000);
		end
		drive(1'b1, 1'b1, 1'b0);
		check("far speech suppress", 15'(transmit_suppress_active), 15'h0001);
		drive(1'b0, 1'b1, 1'b1);
		check("near speech release", 15'(transmit_suppress_active), 15'h0000);
		check("untrained again", 15'(half_duplex_force), 15'h0001);
		// noise guard already off before idle return is set
		host.send(16'h0014, 16);
		check("other address", obs, 15'h0384);
		host.send(16'h5a90, 12);
		check("short frame", obs, 15'h0384);
		// mid run reset brings back the reset image
		rst = 1'b1;
		@(posedge sys_clk);
		#2 rst = 1'b0;
		@(posedge sys_clk);
		#2;
		check("reset again", obs, 15'h5520);
		check("reset force", 15'(half_duplex_force), 15'h0001);
		// first frame right after release must still land
		host.send(16'h5a90, 16);
		check("frame after reset", obs, 15'h2e8c);
		give_verdict();
	end
endmodule : spc_ctrl0_tb
